/* File: verilog/pwr_cfg_pkg.sv */
// Purpose: Shared constants and types for the sleep and wake power selection block.
// Assumes: 32-bit AXI4-Lite byte addresses; power-down bits are active high (1 = off).
// Notes:   Only the low seven power-down bits of each register are modelled.
package pwr_cfg_pkg;

  // Register byte addresses.
  localparam logic [31:0] SLEEP_ADDR = 32'h4004_8230;
  localparam logic [31:0] WAKE_ADDR  = 32'h4004_8234;
  localparam logic [31:0] RUN_ADDR   = 32'h4004_8238;

  // Power-down field positions, shared by all three registers.
  localparam int PD_W          = 7;
  localparam int FAST_OUT_BIT  = 0;
  localparam int FAST_BIT      = 1;
  localparam int FLASH_BIT     = 2;
  localparam int BROWNOUT_BIT  = 3;
  localparam int CONVERTER_BIT = 4;
  localparam int SPARE_BIT     = 5;
  localparam int SLOW_OSC_BIT  = 6;

  // Reset values of the modelled low bits.
  localparam logic [6:0]  SLEEP_RST        = 7'h48;
  localparam logic [6:0]  WAKE_RST         = 7'h50;
  localparam logic [6:0]  RUN_RST          = 7'h78;
  localparam logic [31:0] SLEEP_RSVD_ONES  = 32'h0000_ffb7;

  // Bus responses.
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Power mode of the sequencer.
  typedef enum logic {
    PS_RUN,
    PS_LOW
  } power_state_t;

endpackage

/* File: verilog/pwr_seq_if.sv */
// Purpose: Carries configuration and mode signals between register file and sequencer.
// Assumes: Both ends share aclk.
// Notes:   run_wr is a one-cycle strobe qualified by the register file.
`timescale 1ns/1ps
interface pwr_seq_if;
  logic [6:0] sleep_cfg;
  logic [6:0] wake_cfg;
  logic [6:0] run_wdata;
  logic       run_wr;
  logic       enter;
  logic       wake;
  logic       lock;
  logic [6:0] run_cfg;
  logic [6:0] analog_off;
  logic       low_power;

  modport ctrl (output sleep_cfg, wake_cfg, run_wdata, run_wr, enter, wake, lock,
                input  run_cfg, analog_off, low_power);
  modport seq  (input  sleep_cfg, wake_cfg, run_wdata, run_wr, enter, wake, lock,
                output run_cfg, analog_off, low_power);
endinterface

/* File: verilog/power_seq.sv */
// Purpose: Holds the run-time power selection and drives the analog power-down lines.
// Assumes: enter and wake are one-cycle pulses from the system controller.
// Notes:   Bus writes to the run selection are ignored while in low power.
`timescale 1ns/1ps
module power_seq
  import pwr_cfg_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Register file side.
  pwr_seq_if.seq   sp,
  // Fast oscillator clock gate handshake.
  input wire logic fast_clk_gated
);

  power_state_t state, next_state;
  logic [6:0]   run, next_run;
  logic [6:0]   off, next_off;

  // Next run selection, mode and the resulting power-down lines.
  always_comb begin
    next_state = state;
    next_run   = run;
    case (state)
      PS_RUN: begin
        if (sp.enter) begin
          next_run[BROWNOUT_BIT] = sp.sleep_cfg[BROWNOUT_BIT];
          next_run[SLOW_OSC_BIT] = sp.sleep_cfg[SLOW_OSC_BIT];
          next_state = PS_LOW;
        end else if (sp.run_wr) begin
          next_run = sp.run_wdata;
        end
      end
      PS_LOW: begin
        if (sp.wake) begin
          next_run   = sp.wake_cfg;
          next_state = PS_RUN;
        end
      end
      default: next_state = PS_RUN;
    endcase
    next_run[SPARE_BIT] = 1'b1;
    // The watchdog keeps the slow oscillator alive whatever was selected.
    if (sp.lock) begin
      next_run[SLOW_OSC_BIT] = 1'b0;
    end
    if (next_state == PS_LOW) begin
      next_off = '1;
      next_off[BROWNOUT_BIT] = next_run[BROWNOUT_BIT];
      next_off[SLOW_OSC_BIT] = next_run[SLOW_OSC_BIT];
    end else begin
      next_off = next_run;
      // In run mode the oscillator only loses power once its clock is cleanly stopped.
      next_off[FAST_BIT] = next_run[FAST_BIT] & fast_clk_gated;
    end
  end

  // State registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= PS_RUN;
      run   <= RUN_RST;
      off   <= RUN_RST;
    end else begin
      state <= next_state;
      run   <= next_run;
      off   <= next_off;
    end
  end

  assign sp.run_cfg    = run;
  assign sp.analog_off = off;
  assign sp.low_power  = (state == PS_LOW);

  property p_copy_on_enter;
    @(posedge aclk) disable iff (!aresetn)
    (state == PS_RUN && sp.enter) |=>
      (state == PS_LOW && run[BROWNOUT_BIT] == $past(sp.sleep_cfg[BROWNOUT_BIT]));
  endproperty
  a_copy_on_enter: assert property (p_copy_on_enter) else $error("sleep copy missed");

  property p_forced_off;
    @(posedge aclk) disable iff (!aresetn)
    (state == PS_LOW) |-> (off[4:0] & 5'h17) == 5'h17 && off[BROWNOUT_BIT] == run[BROWNOUT_BIT];
  endproperty
  a_forced_off: assert property (p_forced_off) else $error("analog not forced off");

  property p_lock_osc;
    @(posedge aclk) disable iff (!aresetn)
    $past(sp.lock) |-> !off[SLOW_OSC_BIT] && !run[SLOW_OSC_BIT];
  endproperty
  a_lock_osc: assert property (p_lock_osc) else $error("slow osc off under lock");

  property p_wake_load;
    @(posedge aclk) disable iff (!aresetn)
    (state == PS_LOW && sp.wake) |=>
      (state == PS_RUN && run[4:2] == $past(sp.wake_cfg[4:2]));
  endproperty
  a_wake_load: assert property (p_wake_load) else $error("wake selection not applied");

  property p_wake_fast;
    @(posedge aclk) disable iff (!aresetn)
    (state == PS_LOW && sp.wake) |=> run[1:0] == $past(sp.wake_cfg[1:0]);
  endproperty
  a_wake_fast: assert property (p_wake_fast) else $error("fast osc wake bits wrong");

  property p_fast_wait;
    @(posedge aclk) disable iff (!aresetn)
    (state == PS_RUN && off[FAST_BIT]) |-> $past(fast_clk_gated) && run[FAST_BIT];
  endproperty
  a_fast_wait: assert property (p_fast_wait) else $error("fast osc off before gating");

endmodule // power_seq

/* File: verilog/sleep_wake_power_config.sv */
// Purpose: AXI4-Lite register file for deep-sleep, wake-up and run power selections.
// Assumes: Single clock; system controller pulses sleep_enter and wake_event.
// Notes:   Only byte lane 0 carries writable bits; other lanes are ignored.
`timescale 1ns/1ps
// Contract
// - On entry to deep-sleep or power-down the brownout and slow oscillator selections are copied into the run selection.
// - In low power every analog block is forced off except the brownout detector and slow oscillator, which follow the sleep selection.
// - While the watchdog lock is set, a slow oscillator power-down in the sleep selection is overridden so it keeps running.
// - Sleep selection bit 3 powers the brownout detector down in low power when 1, and resets to 1.
// - Sleep selection bit 6 powers the slow oscillator down in low power when 1, resets to 1, and has no effect under the lock.
// - The wake selection bits 2, 3 and 4 pick flash, brownout and converter power on wake, resetting to 0, 0 and 1.
// - The wake selection bits 0 and 1 pick fast oscillator output and oscillator power on wake, both resetting to 0.
// - Wake selection bit 6 picks slow oscillator power on wake, resets to 1, and a power-down is ignored under the lock.
// - In run mode a run selection write acts at once, except fast oscillator power-down, which waits for a clean clock stop; in low power it is ignored.
module sleep_wake_power_config
  import pwr_cfg_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  // Clock and reset.
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address and data.
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // AXI4-Lite write response.
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read.
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // System controller.
  input  wire logic              sleep_enter,
  input  wire logic              wake_event,
  input  wire logic              watchdog_lock,
  // Analog power control.
  output logic [6:0]             analog_off,
  output logic                   low_power,
  output logic                   fast_clk_gate_req,
  input  wire logic              fast_clk_gated
);

  // The full address is decoded, so the bus must present all 32 bits.
  if (ADDR_W != 32) begin : g_bad_addr_w
    $error("ADDR_W must be 32");
  end

  // True for any of the three mapped register addresses.
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a == SLEEP_ADDR) || (a == WAKE_ADDR) || (a == RUN_ADDR);
  endfunction

  pwr_seq_if sq ();

  logic              aw_held, next_aw_held;
  logic [ADDR_W-1:0] waddr, next_waddr;
  logic              w_held, next_w_held;
  logic [31:0]       wbuf, next_wbuf;
  logic              wlane0, next_wlane0;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic [6:0]        sleep_sel, next_sleep_sel;
  logic [6:0]        wake_sel, next_wake_sel;
  logic              do_write;

  // Address and data are caught separately so either may arrive first.
  assign awready  = !aw_held;
  assign wready   = !w_held;
  assign do_write = aw_held && w_held && !bvalid;

  // Write channel and writable configuration registers.
  always_comb begin
    next_aw_held   = aw_held;
    next_waddr     = waddr;
    next_w_held    = w_held;
    next_wbuf      = wbuf;
    next_wlane0    = wlane0;
    next_bvalid    = bvalid;
    next_bresp     = bresp;
    next_sleep_sel = sleep_sel;
    next_wake_sel  = wake_sel;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_waddr   = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_wbuf   = wdata;
      next_wlane0 = wstrb[0];
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = mapped(waddr) ? RESP_OKAY : RESP_SLVERR;
      if (wlane0 && waddr == SLEEP_ADDR) begin
        next_sleep_sel[BROWNOUT_BIT] = wbuf[BROWNOUT_BIT];
        next_sleep_sel[SLOW_OSC_BIT] = wbuf[SLOW_OSC_BIT];
      end else if (wlane0 && waddr == WAKE_ADDR) begin
        next_wake_sel[4:0] = wbuf[4:0];
        // A power-down request is dropped while the watchdog holds the lock.
        if (!(watchdog_lock && wbuf[SLOW_OSC_BIT])) begin
          next_wake_sel[SLOW_OSC_BIT] = wbuf[SLOW_OSC_BIT];
        end
      end
    end
    // The lock overwrites whatever the sleep selection holds for the slow oscillator.
    if (watchdog_lock) begin
      next_sleep_sel[SLOW_OSC_BIT] = 1'b0;
    end
  end

  // Write channel and selection registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      waddr     <= '0;
      w_held    <= 1'b0;
      wbuf      <= 32'h0000_0000;
      wlane0    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
      sleep_sel <= SLEEP_RST;
      wake_sel  <= WAKE_RST;
    end else begin
      aw_held   <= next_aw_held;
      waddr     <= next_waddr;
      w_held    <= next_w_held;
      wbuf      <= next_wbuf;
      wlane0    <= next_wlane0;
      bvalid    <= next_bvalid;
      bresp     <= next_bresp;
      sleep_sel <= next_sleep_sel;
      wake_sel  <= next_wake_sel;
    end
  end

  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;

  // Read channel: one outstanding read, answered the cycle after acceptance.
  assign arready = !rvalid;

  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp  = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      if (araddr == SLEEP_ADDR) begin
        next_rdata = SLEEP_RSVD_ONES | {25'h0, sleep_sel};
      end else if (araddr == WAKE_ADDR) begin
        next_rdata = {25'h0, wake_sel};
      end else if (araddr == RUN_ADDR) begin
        next_rdata = {25'h0, sq.run_cfg};
      end else begin
        next_rdata = 32'h0000_0000;
      end
    end
  end

  // Read channel registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata  <= next_rdata;
      rresp  <= next_rresp;
    end
  end

  // Sequencer hookup; run selection writes pass straight through.
  assign sq.sleep_cfg = sleep_sel;
  assign sq.wake_cfg  = wake_sel;
  assign sq.run_wdata = wbuf[6:0];
  assign sq.run_wr    = do_write && wlane0 && (waddr == RUN_ADDR);
  assign sq.enter     = sleep_enter;
  assign sq.wake      = wake_event;
  assign sq.lock      = watchdog_lock;

  power_seq power_seq_inst (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .sp             (sq.seq),
    .fast_clk_gated (fast_clk_gated)
  );

  assign analog_off        = sq.analog_off;
  assign low_power         = sq.low_power;
  assign fast_clk_gate_req = sq.run_cfg[FAST_BIT];  // Request clock stop first.

  property p_sleep_reset;
    @(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> sleep_sel == SLEEP_RST && wake_sel == WAKE_RST;
  endproperty
  a_sleep_reset: assert property (p_sleep_reset) else $error("bad reset selection");

  property p_sleep_write;
    @(posedge aclk) disable iff (!aresetn)
    (do_write && wlane0 && waddr == SLEEP_ADDR) |=>
      sleep_sel[BROWNOUT_BIT] == $past(wbuf[BROWNOUT_BIT]);
  endproperty
  a_sleep_write: assert property (p_sleep_write) else $error("brownout select lost");

  property p_sleep_lock;
    @(posedge aclk) disable iff (!aresetn)
    watchdog_lock |=> !sleep_sel[SLOW_OSC_BIT];
  endproperty
  a_sleep_lock: assert property (p_sleep_lock) else $error("slow osc select not overridden");

  property p_wake_lock;
    @(posedge aclk) disable iff (!aresetn)
    (watchdog_lock && !wake_sel[SLOW_OSC_BIT]) |=> !wake_sel[SLOW_OSC_BIT];
  endproperty
  a_wake_lock: assert property (p_wake_lock) else $error("wake slow osc set under lock");

  property p_bresp_follows;
    @(posedge aclk) disable iff (!aresetn)
    do_write |=> bvalid && (bresp == (mapped($past(waddr)) ? RESP_OKAY : RESP_SLVERR));
  endproperty
  a_bresp_follows: assert property (p_bresp_follows) else $error("write response wrong");

  // A response must not change or vanish before the master has taken it.
  property p_bvalid_hold;
    @(posedge aclk) disable iff (!aresetn)
    (bvalid && !bready) |=> bvalid && $stable(bresp);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped early");

  property p_rvalid_hold;
    @(posedge aclk) disable iff (!aresetn)
    (rvalid && !rready) |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped early");

  property p_read_unmapped;
    @(posedge aclk) disable iff (!aresetn)
    (arvalid && arready && !mapped(araddr)) |=> rresp == RESP_SLVERR && rdata == 32'h0000_0000;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not refused");

  // Sleep bits 15 to 0 other than the two live bits always read back as ones; bits 31 to 16 read as zero.
  property p_read_sleep;
    @(posedge aclk) disable iff (!aresetn)
    (arvalid && arready && araddr == SLEEP_ADDR) |=>
      rdata == (SLEEP_RSVD_ONES | {25'h0, $past(sleep_sel)});
  endproperty
  a_read_sleep: assert property (p_read_sleep) else $error("sleep readback wrong");

  property p_read_wake;
    @(posedge aclk) disable iff (!aresetn)
    (arvalid && arready && araddr == WAKE_ADDR) |=> rdata == {25'h0, $past(wake_sel)};
  endproperty
  a_read_wake: assert property (p_read_wake) else $error("wake readback wrong");

  property p_wake_write;
    @(posedge aclk) disable iff (!aresetn)
    (do_write && wlane0 && waddr == WAKE_ADDR) |=> wake_sel[4:0] == $past(wbuf[4:0]);
  endproperty
  a_wake_write: assert property (p_wake_write) else $error("wake write lost");

  // Without lane 0 nothing changes; the lock is excluded as it moves bit 6 itself.
  property p_no_lane0;
    @(posedge aclk) disable iff (!aresetn)
    (do_write && !wlane0 && !watchdog_lock) |=> $stable(sleep_sel) && $stable(wake_sel);
  endproperty
  a_no_lane0: assert property (p_no_lane0) else $error("write without lane 0 took effect");

  property p_enter_out;
    @(posedge aclk) disable iff (!aresetn)
    (sleep_enter && !low_power) |=> low_power;
  endproperty
  a_enter_out: assert property (p_enter_out) else $error("low power not entered");

  property p_wake_out;
    @(posedge aclk) disable iff (!aresetn)
    (wake_event && low_power) |=> !low_power;
  endproperty
  a_wake_out: assert property (p_wake_out) else $error("low power not left");

  property p_low_forced;
    @(posedge aclk) disable iff (!aresetn)
    low_power |-> (analog_off & 7'h37) == 7'h37;
  endproperty
  a_low_forced: assert property (p_low_forced) else $error("analog line on in low power");

  property p_lock_out;
    @(posedge aclk) disable iff (!aresetn)
    watchdog_lock |=> !analog_off[SLOW_OSC_BIT];
  endproperty
  a_lock_out: assert property (p_lock_out) else $error("slow osc line off under lock");

  // A run write in run mode lands on the next edge, spare bit 5 aside, and bit 6 aside when locked.
  property p_run_write;
    @(posedge aclk) disable iff (!aresetn)
    (sq.run_wr && !low_power && !sleep_enter && !watchdog_lock) |=>
      sq.run_cfg[4:0] == $past(wbuf[4:0]) && sq.run_cfg[SLOW_OSC_BIT] == $past(wbuf[SLOW_OSC_BIT]);
  endproperty
  a_run_write: assert property (p_run_write) else $error("run write not applied");

endmodule // sleep_wake_power_config

/* File: sim/sleep_wake_power_config_tb.sv */
// Purpose: Self-checking bench for the sleep and wake power selection block.
// Assumes: AXI4-Lite answers are awaited, never counted; lock and gate inputs are levels.
// Notes:   Only byte lane 0 carries data; upper register bits are not exercised.
`timescale 1ns/1ps
module sleep_wake_power_config_tb;
  import pwr_cfg_pkg::*;
  logic        aclk;
  logic        aresetn;
  logic [31:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [31:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        sleep_enter;
  logic        wake_event;
  logic        watchdog_lock;
  logic [6:0]  analog_off;
  logic        low_power;
  logic        fast_clk_gate_req;
  logic        fast_clk_gated;
  int          miscompares;
  int          comparisons;

  sleep_wake_power_config #(.ADDR_W(32)) sleep_wake_power_config_inst (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .sleep_enter(sleep_enter), .wake_event(wake_event), .watchdog_lock(watchdog_lock),
    .analog_off(analog_off), .low_power(low_power),
    .fast_clk_gate_req(fast_clk_gate_req), .fast_clk_gated(fast_clk_gated)
  );

  // Free-running 25 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Compares a word; narrower results are zero-extended by the caller.
  task automatic check_val(input logic [31:0] act, input logic [31:0] exp);
    comparisons++;
    if (act !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got %h expected %h", $time, act, exp);
    end
  endtask

  task automatic check_resp(input logic [1:0] act, input logic [1:0] exp);
    comparisons++;
    if (act !== exp) begin
      miscompares++;
      $display("FAIL t=%0t resp got %h expected %h", $time, act, exp);
    end
  endtask

  // A hung handshake would stall the run, so each wait is bounded.
  task automatic give_up(input int n);
    if (n >= 50) begin
      miscompares++;
      complete_run();
    end
  endtask

  // Address and data are offered together and each is dropped once taken.
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] exp);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 50);
    give_up(n);
    check_resp(bresp, exp);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] mask, input logic [31:0] exp,
                    input logic [1:0] rexp);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 50);
    give_up(n);
    check_val(rdata & mask, exp);
    check_resp(rresp, rexp);
    rready <= 1'b0;
  endtask

  // One-cycle mode pulse; outputs are looked at once the taking edge has landed.
  task automatic pulse(input bit go_low);
    @(posedge aclk);
    if (go_low) sleep_enter <= 1'b1;
    else wake_event <= 1'b1;
    @(posedge aclk);
    sleep_enter <= 1'b0;
    wake_event  <= 1'b0;
    @(posedge aclk);
    #1;
  endtask

  task automatic check_off(input logic [6:0] mask, input logic [6:0] exp);
    check_val({25'h0, analog_off & mask}, {25'h0, exp});
  endtask

  // Watchdog: the tests need well under a thousand cycles.
  initial begin
    repeat (3000) @(posedge aclk);
    miscompares++;
    complete_run();
  end

  // Main sequence.
  initial begin
    miscompares = 0;
    comparisons = 0;
    aresetn = 1'b0;
    {awaddr, wdata, araddr} = '0;
    {awvalid, wvalid, bready, arvalid, rready, wstrb} = '0;
    {sleep_enter, wake_event, watchdog_lock, fast_clk_gated} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    check_off(7'h7f, 7'h78);
    check_val({31'h0, low_power}, 32'h0);
    rd(SLEEP_ADDR, 32'hffff_ffff, 32'h0000_ffff, RESP_OKAY);
    rd(WAKE_ADDR, 32'hffff_ffff, 32'h50, RESP_OKAY);
    // Every wake bit, a write with lane 0 disabled, and an unmapped place.
    wr(WAKE_ADDR, 32'h5f, 4'hf, RESP_OKAY);
    rd(WAKE_ADDR, 32'hffff_ffff, 32'h5f, RESP_OKAY);
    wr(WAKE_ADDR, 32'h0, 4'he, RESP_OKAY);
    rd(WAKE_ADDR, 32'hffff_ffff, 32'h5f, RESP_OKAY);
    wr(32'h4004_8240, 32'h0, 4'hf, RESP_SLVERR);
    rd(32'h4004_8240, 32'hffff_ffff, 32'h0, RESP_SLVERR);
    // Sleep selection keeps both blocks running; wake powers everything on except the spare.
    wr(WAKE_ADDR, 32'h0, 4'hf, RESP_OKAY);
    wr(SLEEP_ADDR, 32'h0, 4'hf, RESP_OKAY);
    rd(SLEEP_ADDR, 32'hffff_ffff, 32'hffb7, RESP_OKAY);
    pulse(1'b1);
    check_val({31'h0, low_power}, 32'h1);
    check_off(7'h7f, 7'h37);
    rd(RUN_ADDR, 32'h48, 32'h0, RESP_OKAY);
    pulse(1'b0);
    check_val({31'h0, low_power}, 32'h0);
    check_off(7'h5f, 7'h00);
    rd(RUN_ADDR, 32'hffff_ffff, 32'h20, RESP_OKAY);
    // Sleep selection powers both down; wake applies a mixed selection.
    wr(WAKE_ADDR, 32'h5d, 4'hf, RESP_OKAY);
    wr(SLEEP_ADDR, 32'h48, 4'hf, RESP_OKAY);
    pulse(1'b1);
    check_off(7'h7f, 7'h7f);
    rd(RUN_ADDR, 32'h48, 32'h48, RESP_OKAY);
    pulse(1'b0);
    check_off(7'h5f, 7'h5d);
    rd(RUN_ADDR, 32'hffff_ffff, 32'h7d, RESP_OKAY);
    // Under the watchdog lock the slow oscillator cannot be powered down.
    wr(WAKE_ADDR, 32'h0, 4'hf, RESP_OKAY);
    @(posedge aclk);
    watchdog_lock <= 1'b1;
    repeat (2) @(posedge aclk);
    wr(SLEEP_ADDR, 32'h48, 4'hf, RESP_OKAY);
    rd(SLEEP_ADDR, 32'hffff_ffff, 32'hffbf, RESP_OKAY);
    wr(WAKE_ADDR, 32'h40, 4'hf, RESP_OKAY);
    rd(WAKE_ADDR, 32'hffff_ffff, 32'h0, RESP_OKAY);
    pulse(1'b1);
    check_off(7'h7f, 7'h3f);
    pulse(1'b0);
    check_off(7'h40, 7'h00);
    @(posedge aclk);
    watchdog_lock <= 1'b0;
    // Output gate acts at once; the oscillator waits for its clock to stop.
    wr(RUN_ADDR, 32'h3, 4'hf, RESP_OKAY);
    repeat (2) @(posedge aclk);
    #1;
    check_off(7'h03, 7'h01);
    check_val({31'h0, fast_clk_gate_req}, 32'h1);
    @(posedge aclk);
    fast_clk_gated <= 1'b1;
    repeat (3) @(posedge aclk);
    #1;
    check_off(7'h03, 7'h03);
    wr(RUN_ADDR, 32'h78, 4'hf, RESP_OKAY);
    repeat (2) @(posedge aclk);
    #1;
    check_off(7'h7f, 7'h78);
    complete_run();
  end
endmodule // sleep_wake_power_config_tb
